/* File: sim/vvc_partner.sv */
// far-side model: vbus comparator, debouncer, strap sampler and vconn discharge sense
`timescale 1ns/1ps
`default_nettype none
module vvc_partner (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic [1:0] comp_source_i,
	input  wire logic       comp_enable_i,
	input  wire logic [1:0] discharge_i,
	input  wire logic       slow_i,
	output logic            db_active_o,
	output logic            sample_done_o,
	output logic            level_o,
	output logic            time_o
);
	logic [3:0] scnt_q;
	logic [4:0] dcnt_q;

	// slow mode lets the timer expire before the level is reached
	assign level_o = dcnt_q >= (slow_i ? 5'h0C : 5'h03);
	assign time_o  = dcnt_q >= 5'h08;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			db_active_o   <= 1'b0;
			sample_done_o <= 1'b0;
			scnt_q        <= 4'h0;
			dcnt_q        <= 5'h00;
		end else begin
			db_active_o   <= comp_enable_i && comp_source_i == 2'h1;
			sample_done_o <= comp_source_i[1] && scnt_q == (slow_i ? 4'h6 : 4'h2);
			scnt_q        <= (comp_source_i[1] && !sample_done_o) ? scnt_q + 4'h1 : 4'h0;
			dcnt_q        <= (discharge_i == 2'h0) ? 5'h00 : dcnt_q + {4'h0, dcnt_q != 5'h1F};
		end
	end
endmodule
`default_nettype wire

/* File: sim/vvc_regs_sva.sv */
// port assertions for the vbus/vconn control bank
`timescale 1ns/1ps
`default_nettype none
module vvc_regs_sva (
	input wire logic        ref_clk_i,
	input wire logic        resetn_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        supply_debounce_active_i,
	input wire logic        cfg_sample_done_i,
	input wire logic        vconn1_fet_en_o,
	input wire logic        vconn2_fet_en_o,
	input wire logic        cable_power_discharge_error_o,
	input wire logic [1:0]  comp_source_o,
	input wire logic        comp_enable_o,
	input wire logic [9:0]  vbus_threshold0_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside answer cycle");
	a_unmapped_zero: assert property ($past(reg_rd_i) && !($past(reg_addr_i) inside {[16'h0840:16'h0849]})
		|-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_thr_rsvd: assert property ($past(reg_rd_i)
		&& $past(reg_addr_i) inside {16'h0843, 16'h0845, 16'h0847, 16'h0849}
		|-> reg_rdata_o[7:2] == 6'h00) else $error("threshold upper bits not zero");
	a_ctl_rsvd: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 16'h0841
		|-> reg_rdata_o[7:4] == 4'h0) else $error("control upper bits not zero");
	a_dbact_read: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 16'h0840
		|-> reg_rdata_o[7] == $past(supply_debounce_active_i)) else $error("debounce bit mismatch");
	a_thr_commit: assert property (reg_wr_i && reg_addr_i == 16'h0843
		|=> vbus_threshold0_o[9:8] == $past(reg_wdata_i[1:0])) else $error("threshold not committed");
	a_thr_stable: assert property (!$stable(vbus_threshold0_o)
		|-> $past(reg_wr_i) && $past(reg_addr_i) == 16'h0843) else $error("threshold moved without high write");
	a_cfg_clear: assert property (comp_source_o[1] && cfg_sample_done_i && !reg_wr_i
		|=> comp_source_o == 2'h0) else $error("comparator field not cleared");
	a_comp_en: assert property (comp_enable_o == (comp_source_o != 2'h0))
		else $error("comparator enable mismatch");
	a_err_fets: assert property (cable_power_discharge_error_o
		|-> !vconn1_fet_en_o && !vconn2_fet_en_o) else $error("fet on during error");
	a_err_pulse: assert property (cable_power_discharge_error_o |=> !cable_power_discharge_error_o)
		else $error("error pulse longer than one cycle");
endmodule

bind vvc_regs vvc_regs_sva u_sva (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .supply_debounce_active_i, .cfg_sample_done_i, .vconn1_fet_en_o, .vconn2_fet_en_o,
	.cable_power_discharge_error_o, .comp_source_o, .comp_enable_o, .vbus_threshold0_o);
`default_nettype wire

/* File: sim/vvc_regs_test.sv */
// self-checking bench for the vbus/vconn control bank
`timescale 1ns/1ps
`default_nettype none
module vvc_regs_test;
	import vvc_pkg::*;
	logic        clk, rstn, wr, rd, sa, dfp, bd1, bd2, ocs, voc, dchg, dsel, slow;
	logic        f1, f2, err, cen, lci, ocn, dba, sdone, lvl, tim;
	logic [15:0] addr, rv, nv;
	logic [7:0]  wd, rdo;
	logic [1:0]  sreq, vdis, csrc;
	logic [9:0]  thr [4];
	logic [9:0]  exp_thr [4];
	int          miscompares, cmp_count, cyc, i, n;

	vvc_partner u_far (.clk_i(clk), .rstn_i(rstn), .comp_source_i(csrc), .comp_enable_i(cen),
		.discharge_i(vdis), .slow_i(slow), .db_active_o(dba), .sample_done_o(sdone), .level_o(lvl), .time_o(tim));

	vvc_regs #(.OC_HOLD0_CYC(20), .OC_HOLD1_CYC(40), .OC_HOLD2_CYC(80), .OC_HOLD3_CYC(120)) dut (
		.ref_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdo), .mode_standalone_i(sa), .mode_dfp_i(dfp), .cc1_backdrive_i(bd1),
		.cc2_backdrive_i(bd2), .vconn_ocs_i(ocs), .vbus_overcurrent_i(voc), .cable_power_discharge_level_i(lvl),
		.supply_debounce_active_i(dba), .cfg_sample_done_i(sdone), .vbus_discharging_i(dchg),
		.discharge_select_i(dsel), .sa_vconn_req_i(sreq), .cable_power_discharge_time_i(tim),
		.vconn1_fet_en_o(f1), .vconn2_fet_en_o(f2), .vconn_discharge_o(vdis), .cable_power_discharge_error_o(err),
		.comp_source_o(csrc), .comp_enable_o(cen), .low_current_indicate_o(lci), .overcurrent_flag_n_o(ocn),
		.vbus_threshold0_o(thr[0]), .vbus_threshold1_o(thr[1]), .vbus_threshold2_o(thr[2]),
		.vbus_threshold3_o(thr[3]));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			print_verdict();
		end
	end

	function logic [9:0] thr_rst(input int k);
		return (k == 0) ? 10'h094 : 10'h0DE;
	endfunction

	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task w8(input logic [15:0] a, input logic [7:0] d);
		addr <= a;
		wd   <= d;
		wr   <= 1'b1;
		@(posedge clk);
		wr   <= 1'b0;
		@(posedge clk);
	endtask

	task w16(input logic [15:0] a, input logic [15:0] v);
		addr <= a;
		wd   <= v[7:0];
		wr   <= 1'b1;
		@(posedge clk);
		addr <= a + 16'h0001;
		wd   <= v[15:8];
		@(posedge clk);
		wr   <= 1'b0;
	endtask

	task r16(input logic [15:0] a);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		addr <= a + 16'h0001;
		@(negedge clk);
		rv[7:0] = rdo;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		rv[15:8] = rdo;
		@(posedge clk);
	endtask

	task rst(input logic s, input logic d);
		rstn <= 1'b0;
		sa   <= s;
		dfp  <= d;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task wait_err(input int lim);
		n = 0;
		while (err !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(16'(n < lim), 16'h0001);
	endtask

	task print_verdict;
		$display("comparisons=%0d miscompares=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		{rstn, wr, rd, sa, bd1, bd2, ocs, voc, dchg, dsel, slow} = 11'h000;
		dfp = 1'b1;
		addr = 16'h0000;
		wd = 8'h00;
		sreq = 2'h0;
		{miscompares, cmp_count, cyc} = {32'h0, 32'h0, 32'h0};
		void'($urandom(22));
		rst(1'b0, 1'b1);
		// reset contents
		for (i = 0; i < 4; i++) begin
			exp_thr[i] = thr_rst(i);
			chk({6'h00, thr[i]}, {6'h00, exp_thr[i]});
			r16(16'h0842 + 16'(i * 2));
			chk(rv, {6'h00, exp_thr[i]});
		end
		r16(16'h0840);
		chk(rv, 16'h0000);
		// thresholds: low byte alone holds, high byte commits
		for (n = 0; n < 8; n++) begin
			i = $urandom_range(3);
			nv = (n == 0) ? 16'hFFFF : 16'($urandom);
			w8(16'h0842 + 16'(i * 2), nv[7:0]);
			chk({6'h00, thr[i]}, {6'h00, exp_thr[i]});
			w8(16'h0843 + 16'(i * 2), nv[15:8]);
			exp_thr[i] = nv[9:0];
			chk({6'h00, thr[i]}, {6'h00, exp_thr[i]});
			r16(16'h0842 + 16'(i * 2));
			chk(rv, {6'h00, exp_thr[i]});
		end
		// control fields with vbus sampling on
		repeat (6) begin
			nv = 16'($urandom);
			nv[1:0] = 2'h1;
			nv[5:4] = 2'h0;
			w16(16'h0840, nv);
			repeat (3) @(posedge clk);
			chk({14'h0, f2, f1}, {14'h0, nv[3:2]});
			r16(16'h0840);
			chk(rv, (nv & 16'h0F7F) | 16'h0080);
		end
		w8(16'h0840, 8'h00);
		n = 0;
		rv = 16'h0080;
		while (rv[7] !== 1'b0 && n < 10) begin
			r16(16'h0840);
			n++;
		end
		chk(16'(n < 10), 16'h0001);
		// strap pin samples clear the field
		for (i = 2; i < 4; i++) begin
			w8(16'h0840, 8'(i));
			n = 0;
			while (csrc !== 2'h0 && n < 20) begin
				@(posedge clk);
				n++;
			end
			r16(16'h0840);
			chk({14'h0, rv[1:0]}, 16'h0000);
			chk({15'h0, cen}, 16'h0000);
		end
		// over-current on vconn with and without the watch
		w8(16'h0840, 8'h4C);
		ocs <= 1'b1;
		wait_err(10);
		@(posedge clk);
		chk({14'h0, f2, f1}, 16'h0000);
		ocs <= 1'b0;
		r16(16'h0840);
		chk({14'h0, rv[3:2]}, 16'h0000);
		w8(16'h0840, 8'h0C);
		ocs <= 1'b1;
		repeat (10) @(posedge clk);
		chk({14'h0, f2, f1}, 16'h0003);
		ocs <= 1'b0;
		// back-drive on cc1 cuts only that fet
		w16(16'h0840, 16'h080C);
		bd1 <= 1'b1;
		repeat (6) @(posedge clk);
		chk({14'h0, f2, f1}, 16'h0002);
		bd1 <= 1'b0;
		w8(16'h084A, 8'hFF);
		r16(16'h084A);
		chk(rv, 16'h0000);
		// standalone dfp
		rst(1'b1, 1'b1);
		r16(16'h0840);
		chk(rv & 16'h0840, 16'h0840);
		voc <= 1'b1;
		@(posedge clk);
		voc <= 1'b0;
		n = 0;
		while (ocn !== 1'b0 && n < 8) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (ocn === 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(16'(n >= 20 && n <= 26), 16'h0001);
		w16(16'h0840, 16'h044C);
		dchg <= 1'b1;
		repeat (4) @(posedge clk);
		chk({15'h0, lci}, 16'h0001);
		dsel <= 1'b1;
		repeat (4) @(posedge clk);
		chk({15'h0, lci}, 16'h0000);
		dchg <= 1'b0;
		slow <= 1'b1;
		sreq <= 2'h1;
		repeat (6) @(posedge clk);
		chk({14'h0, f2, f1}, 16'h0001);
		sreq <= 2'h0;
		repeat (3) @(posedge clk);
		chk({14'h0, vdis}, 16'h0001);
		wait_err(30);
		// standalone ufp forces vbus sampling
		rst(1'b1, 1'b0);
		w8(16'h0840, 8'h00);
		r16(16'h0840);
		chk({14'h0, rv[1:0]}, 16'h0001);
		print_verdict();
	end
endmodule
`default_nettype wire

/* File: src/vvc_defs.svh */
// register offsets, field positions, reset values and timing counts for the vbus/vconn control bank
`ifndef VVC_DEFS_SVH
`define VVC_DEFS_SVH

// ----------------------------------------------------------------
// byte addresses (each 16-bit register is a low byte then a high byte)
// ----------------------------------------------------------------
`define VVC_ADDR_W          16
`define VVC_OFF_CONTROL     16'h0840
`define VVC_OFF_THR0        16'h0842
`define VVC_OFF_THR1        16'h0844
`define VVC_OFF_THR2        16'h0846
`define VVC_OFF_THR3        16'h0848
`define VVC_NUM_THR         4

// ----------------------------------------------------------------
// control register fields (bit positions in the 16-bit word)
// ----------------------------------------------------------------
`define VVC_BIT_BACKDRIVE   11
`define VVC_BIT_LOW_CUR     10
`define VVC_FLD_OC_HOLD_HI  9
`define VVC_FLD_OC_HOLD_LO  8
`define VVC_BIT_DB_ACTIVE   7
`define VVC_BIT_OCS_EN      6
`define VVC_FLD_DISCH_HI    5
`define VVC_FLD_DISCH_LO    4
`define VVC_BIT_FET2        3
`define VVC_BIT_FET1        2
`define VVC_FLD_COMP_HI     1
`define VVC_FLD_COMP_LO     0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VVC_RST_THR0        10'h094
`define VVC_RST_THR_OTHER   10'h0DE

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define VVC_CLK_KHZ         125000
`define VVC_OC_HOLD0_MS     5
`define VVC_OC_HOLD1_MS     10
`define VVC_OC_HOLD2_MS     20
`define VVC_OC_HOLD3_MS     30
`define VVC_MS_TO_CYC(ms)   ((ms) * `VVC_CLK_KHZ)
`define VVC_OC_CNT_W        22

`endif

/* File: src/vvc_pkg.sv */
// types shared by the vbus/vconn control bank
package vvc_pkg;

	// comparator source field
	typedef enum logic [1:0] {
		VVC_COMP_OFF  = 2'h0,
		VVC_COMP_VBUS = 2'h1,
		VVC_COMP_CFG0 = 2'h2,
		VVC_COMP_CFG1 = 2'h3
	} vvc_comp_e;

	// cable power discharge policy field
	typedef enum logic [1:0] {
		VVC_DIS_EITHER = 2'h0,
		VVC_DIS_NONE   = 2'h1,
		VVC_DIS_LEVEL  = 2'h2,
		VVC_DIS_TIME   = 2'h3
	} vvc_disch_e;

	// discharge sequencer states
	typedef enum logic [1:0] {
		VVC_ST_IDLE = 2'h0,
		VVC_ST_RUN  = 2'h1,
		VVC_ST_END  = 2'h3
	} vvc_state_e;

endpackage

/* File: src/vvc_regs.sv */
// vbus/vconn control and threshold registers with fet, discharge and over-current hold logic
`timescale 1ns/1ps
`default_nettype none
`include "vvc_defs.svh"

module vvc_regs
	import vvc_pkg::*;
#(
	parameter int unsigned OC_HOLD0_CYC = `VVC_MS_TO_CYC(`VVC_OC_HOLD0_MS),
	parameter int unsigned OC_HOLD1_CYC = `VVC_MS_TO_CYC(`VVC_OC_HOLD1_MS),
	parameter int unsigned OC_HOLD2_CYC = `VVC_MS_TO_CYC(`VVC_OC_HOLD2_MS),
	parameter int unsigned OC_HOLD3_CYC = `VVC_MS_TO_CYC(`VVC_OC_HOLD3_MS)
) (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	// register port
	input  wire logic [15:0] reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	// operating mode straps (pins)
	input  wire logic        mode_standalone_i,
	input  wire logic        mode_dfp_i,
	// analog monitors (pins)
	input  wire logic        cc1_backdrive_i,
	input  wire logic        cc2_backdrive_i,
	input  wire logic        vconn_ocs_i,
	input  wire logic        vbus_overcurrent_i,
	input  wire logic        cable_power_discharge_level_i,
	// on-chip partners
	input  wire logic        supply_debounce_active_i,
	input  wire logic        cfg_sample_done_i,
	input  wire logic        vbus_discharging_i,
	input  wire logic        discharge_select_i,
	input  wire logic [1:0]  sa_vconn_req_i,
	input  wire logic        cable_power_discharge_time_i,
	// outputs to the power path
	output logic             vconn1_fet_en_o,
	output logic             vconn2_fet_en_o,
	output logic      [1:0]  vconn_discharge_o,
	output logic             cable_power_discharge_error_o,
	output logic      [1:0]  comp_source_o,
	output logic             comp_enable_o,
	output logic             low_current_indicate_o,
	output logic             overcurrent_flag_n_o,
	output logic      [9:0]  vbus_threshold0_o,
	output logic      [9:0]  vbus_threshold1_o,
	output logic      [9:0]  vbus_threshold2_o,
	output logic      [9:0]  vbus_threshold3_o
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// word offset of a byte address
	function automatic logic [15:0] word_addr(input logic [15:0] a);
		word_addr = {a[15:1], 1'b0};
	endfunction

	// index of the threshold register at a byte address, with hit flag
	function automatic logic [2:0] thr_hit(input logic [15:0] a);
		logic [15:0] w;
		w = word_addr(a);
		case (w)
			`VVC_OFF_THR0: thr_hit = 3'h4;
			`VVC_OFF_THR1: thr_hit = 3'h5;
			`VVC_OFF_THR2: thr_hit = 3'h6;
			`VVC_OFF_THR3: thr_hit = 3'h7;
			default:       thr_hit = 3'h0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int SYN_W = 7;
	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	wire  [SYN_W-1:0] pins_raw = {mode_standalone_i, mode_dfp_i, cc1_backdrive_i, cc2_backdrive_i,
	                              vconn_ocs_i, vbus_overcurrent_i, cable_power_discharge_level_i};

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			syn1_q <= '0;
			syn2_q <= '0;
		end else begin
			syn1_q <= pins_raw;
			syn2_q <= syn1_q;
		end
	end

	wire standalone_s, dfp_s, bd1_s, bd2_s, ocs_s, vbus_oc_s, level_s;
	assign {standalone_s, dfp_s, bd1_s, bd2_s, ocs_s, vbus_oc_s, level_s} = syn2_q;

	wire sa_dfp = standalone_s & dfp_s;
	wire sa_ufp = standalone_s & ~dfp_s;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	wire        ctl_hit  = (word_addr(reg_addr_i) == `VVC_OFF_CONTROL);
	wire [2:0]  thr_sel  = thr_hit(reg_addr_i);
	wire        thr_any  = thr_sel[2];
	wire [1:0]  thr_idx  = thr_sel[1:0];
	wire        hi_byte  = reg_addr_i[0];
	wire        ctl_wr_lo = reg_wr_i & ctl_hit & ~hi_byte;
	wire        ctl_wr_hi = reg_wr_i & ctl_hit & hi_byte;

	// ----------------------------------------------------------------
	// control register state
	// ----------------------------------------------------------------
	logic       backdrive_en_q;
	logic       low_cur_en_q;
	logic [1:0] oc_hold_sel_q;
	logic       ocs_en_q;
	logic [1:0] disch_mode_q;
	logic       fet1_q;
	logic       fet2_q;
	logic [1:0] comp_q;
	logic [1:0] init_cnt_q;
	logic       ocs_s_q;
	logic       err_q;
	logic       err_d;

	// mode straps are valid once they have crossed the synchroniser
	wire init_load = (init_cnt_q == 2'h2);
	wire ocs_event = ocs_s & ~ocs_s_q & ocs_en_q;
	wire bd1_trip  = backdrive_en_q & bd1_s & vconn1_fet_en_o;
	wire bd2_trip  = backdrive_en_q & bd2_s & vconn2_fet_en_o;
	wire cfg_done  = cfg_sample_done_i & comp_q[1];

	logic [1:0] comp_wr;
	assign comp_wr = reg_wdata_i[`VVC_FLD_COMP_HI:`VVC_FLD_COMP_LO];

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			init_cnt_q <= 2'h0;
		end else if (init_cnt_q != 2'h3) begin
			init_cnt_q <= init_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			backdrive_en_q <= 1'b0;
			ocs_en_q       <= 1'b0;
			low_cur_en_q   <= 1'b0;
			oc_hold_sel_q  <= 2'h0;
			disch_mode_q   <= VVC_DIS_EITHER;
		end else if (init_load) begin
			backdrive_en_q <= sa_dfp;
			ocs_en_q       <= sa_dfp;
		end else begin
			if (ctl_wr_hi) begin
				backdrive_en_q <= reg_wdata_i[`VVC_BIT_BACKDRIVE-8];
				low_cur_en_q   <= reg_wdata_i[`VVC_BIT_LOW_CUR-8];
				oc_hold_sel_q  <= reg_wdata_i[`VVC_FLD_OC_HOLD_HI-8:`VVC_FLD_OC_HOLD_LO-8];
			end
			if (ctl_wr_lo) begin
				ocs_en_q     <= reg_wdata_i[`VVC_BIT_OCS_EN];
				disch_mode_q <= reg_wdata_i[`VVC_FLD_DISCH_HI:`VVC_FLD_DISCH_LO];
			end
		end
	end

	// fet enables: hardware clears win over a write in the same cycle
	wire fet1_clr = err_q | (bd1_trip & ~standalone_s);
	wire fet2_clr = err_q | (bd2_trip & ~standalone_s);
	wire fet1_d   = ~fet1_clr & (ctl_wr_lo ? reg_wdata_i[`VVC_BIT_FET1] : fet1_q);
	wire fet2_d   = ~fet2_clr & (ctl_wr_lo ? reg_wdata_i[`VVC_BIT_FET2] : fet2_q);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fet1_q <= 1'b0;
			fet2_q <= 1'b0;
		end else begin
			fet1_q <= fet1_d;
			fet2_q <= fet2_d;
		end
	end

	// comparator source field
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			comp_q <= VVC_COMP_OFF;
		end else if (sa_ufp) begin
			comp_q <= VVC_COMP_VBUS;
		end else if (ctl_wr_lo) begin
			comp_q <= comp_wr;
		end else if (cfg_done) begin
			comp_q <= VVC_COMP_OFF;
		end
	end

	assign comp_source_o = comp_q;
	assign comp_enable_o = (comp_q != VVC_COMP_OFF);

	// ----------------------------------------------------------------
	// fet outputs
	// ----------------------------------------------------------------
	// in standalone mode the fets follow the standalone policy request, cut off by back-drive
	logic [1:0] sa_trip_q;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sa_trip_q <= 2'h0;
		end else begin
			sa_trip_q[0] <= (sa_trip_q[0] | bd1_trip | err_d) & sa_vconn_req_i[0];
			sa_trip_q[1] <= (sa_trip_q[1] | bd2_trip | err_d) & sa_vconn_req_i[1];
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vconn1_fet_en_o <= 1'b0;
			vconn2_fet_en_o <= 1'b0;
		end else if (standalone_s) begin
			vconn1_fet_en_o <= sa_vconn_req_i[0] & ~sa_trip_q[0] & ~bd1_trip & ~err_d;
			vconn2_fet_en_o <= sa_vconn_req_i[1] & ~sa_trip_q[1] & ~bd2_trip & ~err_d;
		end else begin
			// outputs drop on the same edge that raises the error pulse
			vconn1_fet_en_o <= fet1_q & ~bd1_trip & ~err_q & ~err_d;
			vconn2_fet_en_o <= fet2_q & ~bd2_trip & ~err_q & ~err_d;
		end
	end

	// ----------------------------------------------------------------
	// cable power discharge sequencer
	// ----------------------------------------------------------------
	vvc_state_e st_q;
	vvc_state_e st_d;
	logic [1:0] supplier_q;
	logic       fets_on_q;
	logic       time_err;

	wire fets_on    = vconn1_fet_en_o | vconn2_fet_en_o;
	wire disch_go   = sa_dfp & fets_on_q & ~fets_on & (disch_mode_q != VVC_DIS_NONE);
	wire stop_level = level_s & ((disch_mode_q == VVC_DIS_EITHER) | (disch_mode_q == VVC_DIS_LEVEL));
	wire stop_time  = cable_power_discharge_time_i &
	                  ((disch_mode_q == VVC_DIS_EITHER) | (disch_mode_q == VVC_DIS_TIME));
	assign time_err = (st_q == VVC_ST_RUN) & cable_power_discharge_time_i & ~level_s &
	                  (disch_mode_q == VVC_DIS_EITHER);
	assign err_d    = ocs_event | time_err;

	always_comb begin
		st_d = st_q;
		case (st_q)
			VVC_ST_IDLE: begin
				if (disch_go) begin
					st_d = VVC_ST_RUN;
				end
			end
			VVC_ST_RUN: begin
				if (stop_level || stop_time || !sa_dfp) begin
					st_d = VVC_ST_END;
				end
			end
			VVC_ST_END: st_d = VVC_ST_IDLE;
			default:    st_d = VVC_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q       <= VVC_ST_IDLE;
			supplier_q <= 2'h0;
			fets_on_q  <= 1'b0;
			ocs_s_q    <= 1'b0;
			err_q      <= 1'b0;
		end else begin
			st_q      <= st_d;
			fets_on_q <= fets_on;
			ocs_s_q   <= ocs_s;
			err_q     <= err_d;
			if (fets_on) begin
				supplier_q <= {vconn2_fet_en_o, vconn1_fet_en_o};
			end
		end
	end

	assign vconn_discharge_o             = (st_q == VVC_ST_RUN) ? supplier_q : 2'h0;
	assign cable_power_discharge_error_o = err_q;

	// ----------------------------------------------------------------
	// low-current indication
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_current_indicate_o <= 1'b0;
		end else begin
			low_current_indicate_o <= standalone_s & vbus_discharging_i &
			                          ~discharge_select_i & low_cur_en_q;
		end
	end

	// ----------------------------------------------------------------
	// over-current output with minimum hold in standalone dfp mode
	// ----------------------------------------------------------------
	logic [`VVC_OC_CNT_W-1:0] oc_cnt_q;
	wire  [`VVC_OC_CNT_W-1:0] oc_hold_len = (oc_hold_sel_q == 2'h0) ? `VVC_OC_CNT_W'(OC_HOLD0_CYC) :
	                                        (oc_hold_sel_q == 2'h1) ? `VVC_OC_CNT_W'(OC_HOLD1_CYC) :
	                                        (oc_hold_sel_q == 2'h2) ? `VVC_OC_CNT_W'(OC_HOLD2_CYC) :
	                                                                  `VVC_OC_CNT_W'(OC_HOLD3_CYC);

	wire oc_held = (oc_cnt_q != '0);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			oc_cnt_q <= '0;
		end else if (sa_dfp && vbus_oc_s && !oc_held && overcurrent_flag_n_o) begin
			oc_cnt_q <= oc_hold_len - `VVC_OC_CNT_W'(1);
		end else if (oc_held) begin
			oc_cnt_q <= oc_cnt_q - `VVC_OC_CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			overcurrent_flag_n_o <= 1'b1;
		end else begin
			overcurrent_flag_n_o <= ~(vbus_oc_s | (sa_dfp & oc_held));
		end
	end

	// ----------------------------------------------------------------
	// thresholds
	// ----------------------------------------------------------------
	logic [9:0] thr_q [`VVC_NUM_THR];
	logic [7:0] thr_lo_q [`VVC_NUM_THR];

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < `VVC_NUM_THR; i++) begin
				thr_q[i]    <= (i == 0) ? `VVC_RST_THR0 : `VVC_RST_THR_OTHER;
				thr_lo_q[i] <= '0;
			end
		end else if (reg_wr_i && thr_any) begin
			if (!hi_byte) begin
				thr_lo_q[thr_idx] <= reg_wdata_i;
			end else begin
				thr_q[thr_idx] <= {reg_wdata_i[1:0], thr_lo_q[thr_idx]};
			end
		end
	end

	assign vbus_threshold0_o = thr_q[0];
	assign vbus_threshold1_o = thr_q[1];
	assign vbus_threshold2_o = thr_q[2];
	assign vbus_threshold3_o = thr_q[3];

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	wire [15:0] ctl_word = {4'h0, backdrive_en_q, low_cur_en_q, oc_hold_sel_q,
	                        supply_debounce_active_i, ocs_en_q, disch_mode_q,
	                        fet2_q, fet1_q, comp_q};
	wire [15:0] thr_word = {6'h00, thr_q[thr_idx]};
	wire [15:0] rd_word  = ctl_hit ? ctl_word : (thr_any ? thr_word : 16'h0000);
	wire [7:0]  rd_byte  = hi_byte ? rd_word[15:8] : rd_word[7:0];

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_byte : 8'h00;
		end
	end

endmodule
`default_nettype wire
